// ===== inc/mdr_pkg.sv
// Constants, timing figures and state codes for the multiplexed DRAM master
package mdr_pkg;

   // Geometry
   localparam int MDR_ROW_BITS = 8;
   localparam int MDR_ADDR_BITS = 16;
   localparam int MDR_ROWS = 256;
   localparam int MDR_CNT_BITS = 12;

   // Clock period at 200 MHz
   localparam int CLK_PERIOD_NS = 5;

   // Device timing figures in ns
   localparam int COLUMN_ACCESS_TIME_NS = 70;
   localparam int ROW_ACCESS_TIME_NS = 120;
   localparam int OUTPUT_FLOAT_DELAY_NS = 40;
   localparam int PAGE_CYCLE_MIN_NS = 130;
   localparam int ROW_STROBE_LOW_MIN_NS = 120;
   localparam int ROW_STROBE_LOW_MAX_NS = 10000;
   localparam int ROW_PRECHARGE_WIDTH_NS = 80;
   localparam int COLUMN_STROBE_LOW_MIN_NS = 70;
   localparam int COLUMN_STROBE_LOW_MAX_NS = 10000;
   localparam int COLUMN_PRECHARGE_WIDTH_NS = 50;
   localparam int ROW_TO_COLUMN_MIN_NS = 15;
   localparam int ROW_TO_COLUMN_MAX_NS = 50;
   localparam int COLUMN_LOW_TO_ROW_HIGH_NS = 70;
   localparam int COLUMN_HOLD_AFTER_ROW_NS = 150;
   localparam int REFRESH_PERIOD_NS = 4000000;

   // Cycle counts: least times round up, longest round down
   localparam logic [11:0] CAC_CYC = 12'((COLUMN_ACCESS_TIME_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RAS_MIN_CYC = 12'((ROW_STROBE_LOW_MIN_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RAS_MAX_CYC = 12'(ROW_STROBE_LOW_MAX_NS
      / CLK_PERIOD_NS);
   localparam logic [11:0] RP_CYC = 12'((ROW_PRECHARGE_WIDTH_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CAS_MIN_CYC = 12'((COLUMN_STROBE_LOW_MIN_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CP_CYC = 12'((COLUMN_PRECHARGE_WIDTH_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] PC_CYC = 12'((PAGE_CYCLE_MIN_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RCD_MIN_CYC = 12'((ROW_TO_COLUMN_MIN_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RCD_MAX_CYC = 12'(ROW_TO_COLUMN_MAX_NS
      / CLK_PERIOD_NS);
   localparam logic [11:0] RSH_CYC = 12'((COLUMN_LOW_TO_ROW_HIGH_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CSH_CYC = 12'((COLUMN_HOLD_AFTER_ROW_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RAC_CYC = 12'((ROW_ACCESS_TIME_NS
      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

   // Column strobe high time in page mode, covering both limits
   localparam logic [11:0] PAGE_GAP_CYC = (PC_CYC - CAS_MIN_CYC > CP_CYC) ?
      PC_CYC - CAS_MIN_CYC : CP_CYC;
   // Room kept under the row strobe maximum for one more page access
   localparam logic [11:0] PAGE_ROOM_CYC = 12'h0040;

   // Controller states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ROW_SET = 8'h02,
      ST_RCD = 8'h04,
      ST_COL_SET = 8'h08,
      ST_CAS_LOW = 8'h10,
      ST_PAGE_WAIT = 8'h20,
      ST_RAS_HOLD = 8'h40,
      ST_PRE = 8'h80
   } mdr_state_t;

endpackage : mdr_pkg

// ===== inc/mdr_tmr_if.sv
// Load and done handshake between the controller and its delay timer
`timescale 1ns/10ps
interface mdr_tmr_if;
   logic load;
   logic [11:0] value;
   logic done;

   // Side that starts a delay
   modport owner (output load, output value, input done);
   // Side that counts it down
   modport timer (input load, input value, output done);
endinterface : mdr_tmr_if

// ===== logic/mdr_timer.sv
// Down counter that times the controller's strobe phases
`timescale 1ns/10ps
module mdr_timer
   import mdr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Load and done
   mdr_tmr_if.timer t
);

   logic [11:0] cnt_q;
   logic [11:0] cnt_d;

   // Reload on request, else count to zero and stay
   assign cnt_d = t.load ? t.value :
                  (cnt_q != 12'h000) ? cnt_q - 12'h001 : 12'h000;
   assign t.done = (cnt_q == 12'h000);

   // Count register
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= 12'h000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   timer_load_a: assert property (@(posedge clk) disable iff (reset)
      t.load |=> cnt_q == $past(t.value))
      else $error("timer did not take its load value");

endmodule : mdr_timer

// ===== logic/mdr_ctrl.sv
// Master for a 64K x 1 multiplexed-address DRAM with refresh and page mode
`timescale 1ns/10ps
module mdr_ctrl
   import mdr_pkg::*;
#(
   parameter int REFRESH_CYCLES = REFRESH_PERIOD_CYC
)(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Access requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [MDR_ADDR_BITS-1:0] req_addr,
   input wire logic req_wdata,
   // Access completion
   output logic rsp_valid,
   output logic rsp_rdata,
   // Memory pins
   output logic [MDR_ROW_BITS-1:0] mux_addr_bus,
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic write_sel_n,
   output logic data_out,
   output logic data_oe,
   input wire logic data_in
);

   localparam int REF_INTERVAL = REFRESH_CYCLES / MDR_ROWS;
   localparam int RW = $clog2(REF_INTERVAL + 1);
   localparam logic [RW-1:0] REF_LAST = RW'(REF_INTERVAL - 1);

   mdr_state_t state_q, state_d;
   logic [7:0] addr_q, addr_d, row_q, col_q, ref_row_q;
   logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, we_n_q, we_n_d;
   logic dout_q, dout_d, doe_q, doe_d, ready_q, ready_d;
   logic rsp_q, rsp_d, rdata_q, rdata_d, wr_q, wdat_q, ref_q;
   logic ref_pend_q, ref_start, take;
   logic [RW-1:0] ref_cnt_q;
   logic [11:0] ras_cnt_q, cas_cnt_q, ras_hi_q, cas_hi_q;
   wire ref_tick = (ref_cnt_q == REF_LAST);
   wire row_hit = (req_addr[15:8] == row_q);
   wire csh_met = (ras_cnt_q >= CSH_CYC);
   wire ras_min_met = (ras_cnt_q >= RAS_MIN_CYC);
   wire page_room = (ras_cnt_q < RAS_MAX_CYC - PAGE_ROOM_CYC);
   wire page_ok = req_valid & row_hit & ~ref_pend_q & page_room;

   mdr_tmr_if tif ();

   mdr_timer u_timer (
      .clk(clk),
      .reset(reset),
      .t(tif.timer)
   );

   // Request handshake and outputs
   assign take = ready_q & req_valid;
   assign req_ready = ready_q;
   assign rsp_valid = rsp_q;
   assign rsp_rdata = rdata_q;
   assign mux_addr_bus = addr_q;
   assign row_strobe_n = ras_n_q;
   assign col_strobe_n = cas_n_q;
   assign write_sel_n = we_n_q;
   assign data_out = dout_q;
   assign data_oe = doe_q;
   assign ready_d = (state_d == ST_IDLE && !ref_pend_q) ||
                    (state_q == ST_PAGE_WAIT && tif.done && page_ok &&
                     !ready_q);

   // Strobe sequencing
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      ras_n_d = ras_n_q;
      cas_n_d = cas_n_q;
      we_n_d = we_n_q;
      dout_d = dout_q;
      doe_d = doe_q;
      rsp_d = 1'b0;
      rdata_d = rdata_q;
      ref_start = 1'b0;
      tif.load = 1'b0;
      tif.value = 12'h000;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               addr_d = req_addr[15:8];
               state_d = ST_ROW_SET;
            end else if (ref_pend_q) begin
               ref_start = 1'b1;
               addr_d = ref_row_q;
               state_d = ST_ROW_SET;
            end
         end
         ST_ROW_SET: begin
            ras_n_d = 1'b0;
            tif.load = 1'b1;
            tif.value = RCD_MIN_CYC;
            state_d = ST_RCD;
         end
         ST_RCD: begin
            if (tif.done && ref_q) begin
               state_d = ST_RAS_HOLD;
            end else if (tif.done) begin
               addr_d = col_q;
               we_n_d = ~wr_q;
               doe_d = wr_q;
               dout_d = wdat_q;
               state_d = ST_COL_SET;
            end
         end
         ST_COL_SET: begin
            cas_n_d = 1'b0;
            tif.load = 1'b1;
            tif.value = CAS_MIN_CYC;
            state_d = ST_CAS_LOW;
         end
         ST_CAS_LOW: begin
            if (tif.done && csh_met) begin
               cas_n_d = 1'b1;
               we_n_d = 1'b1;
               doe_d = 1'b0;
               rsp_d = 1'b1;
               rdata_d = wr_q ? wdat_q : data_in;
               tif.load = 1'b1;
               tif.value = PAGE_GAP_CYC;
               state_d = ST_PAGE_WAIT;
            end
         end
         ST_PAGE_WAIT: begin
            if (take) begin
               addr_d = req_addr[7:0];
               we_n_d = ~req_write;
               doe_d = req_write;
               dout_d = req_wdata;
               state_d = ST_COL_SET;
            end else if (tif.done && !page_ok && !ready_q) begin
               state_d = ST_RAS_HOLD;
            end
         end
         ST_RAS_HOLD: begin
            if (ras_min_met) begin
               ras_n_d = 1'b1;
               tif.load = 1'b1;
               tif.value = RP_CYC;
               state_d = ST_PRE;
            end
         end
         ST_PRE: begin
            if (tif.done) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State and pin registers
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         addr_q <= 8'h00;
         ras_n_q <= 1'b1;
         cas_n_q <= 1'b1;
         we_n_q <= 1'b1;
         dout_q <= 1'b0;
         doe_q <= 1'b0;
         ready_q <= 1'b0;
         rsp_q <= 1'b0;
         rdata_q <= 1'b0;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         ras_n_q <= ras_n_d;
         cas_n_q <= cas_n_d;
         we_n_q <= we_n_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
         ready_q <= ready_d;
         rsp_q <= rsp_d;
         rdata_q <= rdata_d;
      end
   end

   // Accepted request fields
   always_ff @(posedge clk) begin
      if (reset) begin
         row_q <= 8'h00;
         col_q <= 8'h00;
         wr_q <= 1'b0;
         wdat_q <= 1'b0;
         ref_q <= 1'b0;
      end else begin
         if (take) begin
            row_q <= req_addr[15:8];
            col_q <= req_addr[7:0];
            wr_q <= req_write;
            wdat_q <= req_wdata;
         end
         ref_q <= ref_start | (ref_q & ~take);
      end
   end

   // Refresh pacing, one row per interval; a tick beats a start
   always_ff @(posedge clk) begin
      if (reset) begin
         ref_cnt_q <= '0;
         ref_pend_q <= 1'b0;
         ref_row_q <= 8'h00;
      end else begin
         ref_cnt_q <= ref_tick ? '0 : ref_cnt_q + RW'(1);
         ref_pend_q <= ref_tick | (ref_pend_q & ~ref_start);
         ref_row_q <= ref_start ? ref_row_q + 8'h01 : ref_row_q;
      end
   end

   // Strobe low and high durations, saturating
   always_ff @(posedge clk) begin
      if (reset) begin
         ras_cnt_q <= 12'h000;
         cas_cnt_q <= 12'h000;
         ras_hi_q <= 12'hFFF; // No activation before reset: long idle
         cas_hi_q <= 12'hFFF; // Same for the column strobe
      end else begin
         ras_cnt_q <= ras_n_q ? 12'h000 : ras_cnt_q + {11'h000, ~&ras_cnt_q};
         cas_cnt_q <= cas_n_q ? 12'h000 : cas_cnt_q + {11'h000, ~&cas_cnt_q};
         ras_hi_q <= !ras_n_q ? 12'h000 : ras_hi_q + {11'h000, ~&ras_hi_q};
         cas_hi_q <= !cas_n_q ? 12'h000 : cas_hi_q + {11'h000, ~&cas_hi_q};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence col_fall_s;
      $fell(cas_n_q);
   endsequence

   sequence row_rise_s;
      $rose(ras_n_q);
   endsequence

   row_addr_stable_a: assert property ($fell(ras_n_q) |-> $stable(addr_q))
      else $error("row address moved at row strobe fall");
   col_addr_stable_a: assert property (col_fall_s |-> $stable(addr_q))
      else $error("column address moved at column strobe fall");
   row_low_min_a: assert property (row_rise_s |-> $past(ras_min_met))
      else $error("row strobe low too short");
   row_low_max_a: assert property (!ras_n_q |-> ras_cnt_q < RAS_MAX_CYC)
      else $error("row strobe low too long");
   row_precharge_a: assert property ($fell(ras_n_q) |-> ras_hi_q >= RP_CYC)
      else $error("row precharge too short");
   // Only the first column fall of a row opening; page falls come later
   row_col_delay_a: assert property (col_fall_s ##0
      cas_hi_q >= ras_cnt_q |->
      ras_cnt_q >= RCD_MIN_CYC && ras_cnt_q <= RCD_MAX_CYC)
      else $error("row to column delay out of range");
   col_low_min_a: assert property ($rose(cas_n_q) |->
      $past(cas_cnt_q) >= CAS_MIN_CYC - 12'h001 && !ras_n_q)
      else $error("column strobe low too short");
   col_hold_row_a: assert property ($rose(cas_n_q) |->
      ras_cnt_q > CSH_CYC)
      else $error("column strobe released before row hold");
   col_precharge_a: assert property (col_fall_s ##0 !ras_n_q ##0
      $past(!ras_n_q) |-> cas_hi_q >= CP_CYC)
      else $error("page column precharge too short");
   early_write_a: assert property (col_fall_s ##0 !we_n_q |->
      $past(!we_n_q) && doe_q)
      else $error("write select not low before column strobe");
   refresh_cas_a: assert property (ref_q && !ras_n_q |-> cas_n_q)
      else $error("column strobe fell in refresh");
   read_sample_a: assert property (rsp_q && !wr_q |->
      $past(cas_cnt_q) >= CAC_CYC - 12'h001 &&
      $past(ras_cnt_q) >= RAC_CYC)
      else $error("read data sampled before access time");

endmodule : mdr_ctrl

// ===== tb/mdr_dram_model.sv
// Behavioural 64K x 1 multiplexed memory that watches strobe timing
`timescale 1ns/10ps
module mdr_dram_model
   import mdr_pkg::*;
#(
   parameter int ACCESS_NS = 70
)(
   // Memory pins
   input wire logic [7:0] addr,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic d,
   output logic q,
   // Watch counters
   output int viol,
   output int ras_falls,
   output int ref_cnt,
   output logic [7:0] ref_row,
   output logic [7:0] ref_prev
);
   logic mem [0:65535];
   realtime row_t [0:255];
   logic [7:0] row_q;
   logic [7:0] col_q;
   realtime t_rf, t_rr, t_cf, t_cr, t_a;
   logic col_seen;

   // No history at start
   initial begin
      viol = 0;
      ras_falls = 0;
      ref_cnt = 0;
      ref_row = 8'h00;
      ref_prev = 8'h00;
      q = 1'b0;
   end

   // Time of the last address change
   always @(addr) t_a = $realtime;

   // Row open; stale rows lose their bits
   always @(negedge ras_n) begin
      if (t_rr > 0.0 && $realtime - t_rr < ROW_PRECHARGE_WIDTH_NS) viol++;
      if (t_a >= $realtime) viol++;
      if ($realtime - row_t[addr] > REFRESH_PERIOD_NS) begin
         for (int c = 0; c < 256; c++) mem[{addr, 8'(c)}] = 1'bx;
      end
      row_t[addr] = $realtime;
      row_q = addr;
      ras_falls++;
      col_seen = 1'b0;
      t_rf = $realtime;
   end

   // Row close; a row-only cycle counts as refresh
   // Unknown to high at power-up is no row close
   always @(posedge ras_n) begin
      if (t_rf > 0.0) begin
         if ($realtime - t_rf < ROW_STROBE_LOW_MIN_NS) viol++;
         if ($realtime - t_rf > ROW_STROBE_LOW_MAX_NS) viol++;
         if (!col_seen) begin
            ref_cnt++;
            ref_prev = ref_row;
            ref_row = row_q;
         end else if ($realtime - t_cf < COLUMN_LOW_TO_ROW_HIGH_NS) viol++;
         t_rr = $realtime;
      end
   end

   // Column open; early write stores the bit here
   always @(negedge cas_n) begin
      if ($realtime - t_rf < ROW_TO_COLUMN_MIN_NS) viol++;
      if (col_seen && $realtime - t_cf < PAGE_CYCLE_MIN_NS) viol++;
      if (col_seen && $realtime - t_cr < COLUMN_PRECHARGE_WIDTH_NS) viol++;
      if (t_a >= $realtime) viol++;
      col_q = addr;
      col_seen = 1'b1;
      t_cf = $realtime;
      if (we_n === 1'b0) mem[{row_q, addr}] = d;
   end

   // Read path: wrong bit until access time, then the cell
   always @(negedge cas_n) begin
      if (we_n === 1'b1 && ras_n === 1'b0) begin
         q = ~mem[{row_q, addr}];
         #(ACCESS_NS);
         if ($realtime - t_rf < ROW_ACCESS_TIME_NS)
            #(ROW_ACCESS_TIME_NS - ($realtime - t_rf));
         if (cas_n === 1'b0) q = mem[{row_q, col_q}];
      end
   end

   // Delayed write takes the bit on write select falling
   always @(negedge we_n) begin
      if (cas_n === 1'b0 && ras_n === 1'b0) mem[{row_q, col_q}] = d;
   end

   // Column close; output floats to a changed level
   always @(posedge cas_n) begin
      if (t_cf > 0.0) begin
         if ($realtime - t_cf < COLUMN_STROBE_LOW_MIN_NS) viol++;
         if ($realtime - t_cf > COLUMN_STROBE_LOW_MAX_NS) viol++;
         if ($realtime - t_rf < COLUMN_HOLD_AFTER_ROW_NS) viol++;
         t_cr = $realtime;
      end
      q = ~q;
   end
endmodule : mdr_dram_model

// ===== tb/tb_mdr_ctrl.sv
// Self-checking bench for the multiplexed DRAM master
`timescale 1ns/10ps
module tb_mdr_ctrl;
   // Refresh every 400 cycles keeps the run short
   localparam int REF_CYC = 102400;
   logic clk, reset, req_valid, req_write, req_wdata, rdv;
   logic [15:0] req_addr;
   logic req_ready, rsp_valid, rsp_rdata, data_out, data_oe, data_in;
   logic row_strobe_n, col_strobe_n, write_sel_n, mem_d;
   logic [7:0] mux_addr_bus, ref_row, ref_prev;
   int viol, ras_falls, ref_cnt, error_cnt, n_checks, cyc;

   // Data wire shows the inverse when the master lets go
   assign mem_d = data_oe ? data_out : ~data_out;

   mdr_ctrl #(.REFRESH_CYCLES(REF_CYC)) i_dut (
      .clk(clk), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .mux_addr_bus(mux_addr_bus), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .write_sel_n(write_sel_n),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in));

   mdr_dram_model i_mem (
      .addr(mux_addr_bus), .ras_n(row_strobe_n), .cas_n(col_strobe_n),
      .we_n(write_sel_n), .d(mem_d), .q(data_in), .viol(viol),
      .ras_falls(ras_falls), .ref_cnt(ref_cnt), .ref_row(ref_row),
      .ref_prev(ref_prev));

   // Clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Cycle count with a hang ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // One request, held until taken, then wait for its answer
   task automatic access(input logic w, input logic [15:0] a,
                         input logic wd, output logic rd);
      int n;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= wd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 2000);
      req_valid <= 1'b0;
      chk("ready wait", 16'h0001, 16'(n < 2000));
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 2000);
      chk("answer wait", 16'h0001, 16'(n < 2000));
      rd = rsp_rdata;
   endtask : access

   // Idle pin levels under reset
   task automatic t_reset();
      repeat (10) @(posedge clk);
      chk("reset pins", 16'h0007, {rsp_valid, req_ready, data_oe,
          row_strobe_n, col_strobe_n, write_sel_n});
      reset <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : t_reset

   // Corner addresses written, placed, read back, read again
   task automatic t_data();
      logic [15:0] a [6] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00,
                             16'h1234, 16'hA5C3};
      for (int i = 0; i < 6; i++) begin
         access(1'b1, a[i], i[0], rdv);
         chk("cell", 16'(i[0]), 16'(i_mem.mem[a[i]]));
      end
      for (int i = 0; i < 6; i++) begin
         access(1'b0, a[i], ~i[0], rdv);
         chk("read bit", 16'(i[0]), 16'(rdv));
      end
      // Idle data wire shows 1 here, so a stray write would show
      access(1'b0, a[0], 1'b0, rdv);
      chk("reread", 16'h0000, 16'(rdv));
   endtask : t_data

   // Same-row pair right after a refresh stays in one row opening
   task automatic t_page();
      int n0, r0, c0;
      n0 = ref_cnt;
      r0 = 0;
      while (ref_cnt == n0 && r0 < 1000) begin
         @(posedge clk);
         r0++;
      end
      r0 = ras_falls;
      access(1'b1, 16'h3C10, 1'b1, rdv);
      c0 = cyc;
      access(1'b0, 16'h3C10, 1'b0, rdv);
      chk("page read", 16'h0001, 16'(rdv));
      chk("row opens", 16'h0001, 16'(ras_falls - r0));
      chk("page gap", 16'h0001, 16'(cyc - c0 < 40));
   endtask : t_page

   // Idle time brings row-only cycles on successive rows
   task automatic t_refresh();
      int n;
      n = ref_cnt;
      repeat (1000) @(posedge clk);
      n = ref_cnt - n;
      chk("refresh count", 16'h0001, 16'(n >= 2 && n <= 3));
      chk("refresh step", 16'h0001, 16'(8'(ref_row - ref_prev)));
   endtask : t_refresh

   // Main sequence
   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 1'b0;
      t_reset();
      t_data();
      t_page();
      t_refresh();
      chk("timing faults", 16'h0000, 16'(viol));
      close_out();
   end
endmodule : tb_mdr_ctrl
